// >>> include/pin_select_pkg.sv
package pin_select_pkg;

    // apb word addresses of the register file
    localparam logic [7:0] ADDR_PORT_A_DATA  = 8'h00;
    localparam logic [7:0] ADDR_PORT_A_DIR   = 8'h04;
    localparam logic [7:0] ADDR_PORT_B_DATA  = 8'h08;
    localparam logic [7:0] ADDR_PORT_B_DIR   = 8'h0c;
    localparam logic [7:0] ADDR_PORT_C_DATA  = 8'h10;
    localparam logic [7:0] ADDR_PORT_B_LOW_SEL = 8'h18;
    localparam logic [7:0] ADDR_STROBE_SEL   = 8'h1c;

    // widths of ports and fields
    localparam int PORT_AB_WIDTH   = 16;
    localparam int PORT_C_WIDTH    = 8;
    localparam int LOW_PIN_COUNT   = 8;
    localparam int MODE_WIDTH      = 2;

    // values after power-on reset
    localparam logic [15:0] RESET_PORT_B_LOW_SEL = 16'h0000;
    localparam logic [15:0] RESET_STROBE_SEL     = 16'h5fff;
    localparam logic [15:0] RESET_PORT_DATA      = 16'h0000;
    localparam logic [15:0] RESET_PORT_DIR       = 16'h0000;

    // strobe selector layout
    localparam int UPPER_STROBE_LSB = 14;
    localparam int LOWER_STROBE_LSB = 12;
    localparam logic [11:0] STROBE_RESERVED_ONES = 12'hfff;

    // low port b pins that take a timer clock in mode 01
    localparam int FIRST_CLOCK_PIN = 6;

    typedef enum logic [1:0] {
        MODE_GPIO    = 2'b00,
        MODE_ALT_IN  = 2'b01,
        MODE_TIMER   = 2'b10,
        MODE_PATTERN = 2'b11
    } pin_mode_t;

    typedef enum logic [1:0] {
        STROBE_RSVD_0 = 2'b00,
        STROBE_CHIP   = 2'b01,
        STROBE_COLUMN = 2'b10,
        STROBE_RSVD_3 = 2'b11
    } strobe_mode_t;

endpackage

// >>> design/pin_route_cell.sv
`timescale 1ns/1ps
`default_nettype none

module pin_route_cell
    import pin_select_pkg::*;
#(
    parameter bit CLOCK_CAPABLE = 1'b0
)
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // selection
    input  wire logic [1:0] mode,
    // general-purpose side
    input  wire logic gpio_dir,
    input  wire logic gpio_data,
    // peripheral side
    input  wire logic timer_out,
    input  wire logic timer_drive,
    input  wire logic pattern_out,
    output logic      timer_in,
    // pin side
    input  wire logic pin_in,
    output logic      pin_out,
    output logic      pin_oe_n
);

    wire is_timer   = (mode == MODE_TIMER);
    wire is_pattern = (mode == MODE_PATTERN);
    // reserved 01 on plain pins falls back to gpio, never a stray driver
    wire is_clock   = CLOCK_CAPABLE && (mode == MODE_ALT_IN);
    wire is_gpio    = !is_timer && !is_pattern && !is_clock;

    // next pin drive from the selected function
    wire next_drive = (is_gpio && gpio_dir) || (is_timer && timer_drive) || is_pattern;
    wire next_level = is_pattern ? pattern_out :
                      is_timer   ? timer_out   :
                      is_gpio    ? gpio_data   : 1'b0;

    // clock pins feed the timer in mode 01, capture pins in mode 10
    assign timer_in = (is_clock || (is_timer && !CLOCK_CAPABLE)) ? pin_in : 1'b0;

    // registered pin drive; released while held in reset
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_out  <= 1'b0;
            pin_oe_n <= 1'b1;
        end
        else
        begin
            pin_out  <= next_level;
            pin_oe_n <= !next_drive;
        end
    end

endmodule
`default_nettype wire

// >>> design/port_pin_function_select.sv
// Contract
// - pin 7 modes: gpio, clock d, compare b4, pattern
// - pin 6 modes: gpio, clock c, compare a4, pattern
// - pins 5,4: gpio, reserved, channel 4, pattern
// - pins 3,2: gpio, reserved, channel 3, pattern
// - pins 1,0: gpio, reserved, channel 2, pattern
// - low port b modes reset to gpio
// - strobe selector 16-bit read/write register
// - strobe selector reset only at power-on
// - upper strobe field: 01 chip select, 10 column
// - lower strobe field: 01 chip select, 10 column
// - strobe selector bits 11:0 read one
// - ports a, b bidirectional, c input only
// - one data register per port
// - low selector covers port b pins 7:0
// - low selector cleared only at power-on
`timescale 1ns/1ps
`default_nettype none

module port_pin_function_select
    import pin_select_pkg::*;
(
    // clock and power-on reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // port a pins
    input  wire logic [15:0] port_a_in,
    output logic      [15:0] port_a_out,
    output logic      [15:0] port_a_oe_n,
    // port b pins
    input  wire logic [15:0] port_b_in,
    output logic      [15:0] port_b_out,
    output logic      [15:0] port_b_oe_n,
    // port c pins
    input  wire logic [7:0]  port_c_in,
    input  wire logic        analog_sampling,
    // timer unit, channel 4 and clocks
    input  wire logic        timer_compare_out_b4,
    input  wire logic        timer_compare_out_a4,
    output logic             timer_ext_clock_d,
    output logic             timer_ext_clock_c,
    // timer unit, capture/compare channels 2..4
    input  wire logic [5:0]  timer_capcomp_out,
    input  wire logic [5:0]  timer_capcomp_drive,
    output logic      [5:0]  timer_capcomp_in,
    // pattern generator
    input  wire logic [7:0]  pattern_out,
    input  wire logic [7:0]  pattern_enable,
    // memory controller strobes
    input  wire logic        chip_select_1,
    input  wire logic        chip_select_3,
    input  wire logic        upper_column_strobe,
    input  wire logic        lower_column_strobe,
    output logic             strobe_pin_upper,
    output logic             strobe_pin_lower
);

    // registers
    logic [15:0] port_a_data;
    logic [15:0] port_a_dir;
    logic [15:0] port_b_data;
    logic [15:0] port_b_dir;
    logic [15:0] port_b_low_function_select;
    logic [1:0]  upper_strobe_mode;
    logic [1:0]  lower_strobe_mode;

    // apb phase decode
    wire setup_phase  = psel && !penable;
    wire access_phase = psel && penable;
    wire write_access = access_phase && pwrite;

    // address hits, each one word
    wire hit_a_data   = (paddr == ADDR_PORT_A_DATA);
    wire hit_a_dir    = (paddr == ADDR_PORT_A_DIR);
    wire hit_b_data   = (paddr == ADDR_PORT_B_DATA);
    wire hit_b_dir    = (paddr == ADDR_PORT_B_DIR);
    wire hit_c_data   = (paddr == ADDR_PORT_C_DATA);
    wire hit_b_low    = (paddr == ADDR_PORT_B_LOW_SEL);
    wire hit_strobe   = (paddr == ADDR_STROBE_SEL);
    wire hit_any      = hit_a_data || hit_a_dir || hit_b_data || hit_b_dir
                        || hit_c_data || hit_b_low || hit_strobe;

    // byte lane mask for the low half word
    wire [15:0] lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // pattern-owned bits of port b refuse writes to their data bit
    wire [15:0] b_pattern_lock;

    // zero-wait slave; unmapped addresses report an error
    assign pready  = 1'b1;
    assign pslverr = access_phase && !hit_any;

    // port a and port b pin readback: direction picks register or pin
    wire [15:0] port_a_view = (port_a_dir & port_a_data) | (~port_a_dir & port_a_in);
    wire [15:0] port_b_view = (port_b_dir & port_b_data) | (~port_b_dir & port_b_in);

    // port c reads all ones while the converter samples
    wire [7:0] port_c_view = analog_sampling ? 8'hff : port_c_in;

    // strobe selector image with the low bits forced high
    wire [15:0] strobe_view = {upper_strobe_mode, lower_strobe_mode,
                               STROBE_RESERVED_ONES};

    // read mux; captured at setup so the answer is a flop
    logic [15:0] next_read;
    always_comb
    begin
        next_read = 16'h0000;
        if (hit_a_data)
            next_read = port_a_view;
        else if (hit_a_dir)
            next_read = port_a_dir;
        else if (hit_b_data)
            next_read = port_b_view;
        else if (hit_b_dir)
            next_read = port_b_dir;
        else if (hit_c_data)
            next_read = {8'h00, port_c_view};
        else if (hit_b_low)
            next_read = port_b_low_function_select;
        else if (hit_strobe)
            next_read = strobe_view;
    end

    // read data register, upper half word always zero
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            prdata <= 32'h0000_0000;
        else if (setup_phase && !pwrite)
            prdata <= {16'h0000, next_read};
    end

    // next values of the writable registers
    wire [15:0] next_a_data = (pwdata[15:0] & lane_mask) | (port_a_data & ~lane_mask);
    wire [15:0] next_a_dir  = (pwdata[15:0] & lane_mask) | (port_a_dir & ~lane_mask);
    wire [15:0] b_data_mask = lane_mask & ~b_pattern_lock;
    wire [15:0] next_b_data = (pwdata[15:0] & b_data_mask) | (port_b_data & ~b_data_mask);
    wire [15:0] next_b_dir  = (pwdata[15:0] & lane_mask) | (port_b_dir & ~lane_mask);
    wire [15:0] next_b_low  = (pwdata[15:0] & lane_mask)
                              | (port_b_low_function_select & ~lane_mask);

    // port a registers; only a power-on reset clears them
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            port_a_data <= RESET_PORT_DATA;
            port_a_dir  <= RESET_PORT_DIR;
        end
        else if (write_access)
        begin
            if (hit_a_data)
                port_a_data <= next_a_data;
            if (hit_a_dir)
                port_a_dir <= next_a_dir;
        end
    end

    // port b registers
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            port_b_data <= RESET_PORT_DATA;
            port_b_dir  <= RESET_PORT_DIR;
        end
        else if (write_access)
        begin
            if (hit_b_data)
                port_b_data <= next_b_data;
            if (hit_b_dir)
                port_b_dir <= next_b_dir;
        end
    end

    // low port b selector; no manual reset or sleep input reaches it
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            port_b_low_function_select <= RESET_PORT_B_LOW_SEL;
        else if (write_access && hit_b_low)
            port_b_low_function_select <= next_b_low;
    end

    // strobe selector; written bits 11:0 are dropped, only the
    // upper byte lane carries the two mode fields
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            upper_strobe_mode <= RESET_STROBE_SEL[15:14];
            lower_strobe_mode <= RESET_STROBE_SEL[13:12];
        end
        else if (write_access && hit_strobe && pstrb[1])
        begin
            upper_strobe_mode <= pwdata[UPPER_STROBE_LSB +: 2];
            lower_strobe_mode <= pwdata[LOWER_STROBE_LSB +: 2];
        end
    end

    // strobe pin routing; reserved codes keep the chip select,
    // which is the function the pin wakes up with
    assign strobe_pin_upper = (upper_strobe_mode == STROBE_COLUMN)
                              ? upper_column_strobe : chip_select_1;
    assign strobe_pin_lower = (lower_strobe_mode == STROBE_COLUMN)
                              ? lower_column_strobe : chip_select_3;

    // per-pin peripheral wiring for the low eight pins
    wire [7:0] cell_timer_out;
    wire [7:0] cell_timer_drive;
    wire [7:0] cell_timer_in;

    // pins 7 and 6 take compare outputs, always driven when selected
    assign cell_timer_out   = {timer_compare_out_b4, timer_compare_out_a4,
                               timer_capcomp_out};
    assign cell_timer_drive = {2'b11, timer_capcomp_drive};

    // clock inputs from pins 7 and 6, capture inputs from pins 5..0
    assign timer_ext_clock_d = cell_timer_in[7];
    assign timer_ext_clock_c = cell_timer_in[6];
    assign timer_capcomp_in  = cell_timer_in[5:0];

    // one routing cell per low port b pin
    genvar pin;
    generate
        for (pin = 0; pin < LOW_PIN_COUNT; pin++)
        begin : g_low_pin
            wire [1:0] pin_mode = port_b_low_function_select[MODE_WIDTH*pin +: MODE_WIDTH];

            // a pattern pin with its output enabled owns the data bit
            assign b_pattern_lock[pin] = (pin_mode == MODE_PATTERN) && pattern_enable[pin];

            pin_route_cell #(
                .CLOCK_CAPABLE (pin >= FIRST_CLOCK_PIN)
            ) u_cell (
                .clk_sys     (clk_sys),
                .reset_n     (reset_n),
                .mode        (pin_mode),
                .gpio_dir    (port_b_dir[pin]),
                .gpio_data   (port_b_data[pin]),
                .timer_out   (cell_timer_out[pin]),
                .timer_drive (cell_timer_drive[pin]),
                .pattern_out (pattern_out[pin]),
                .timer_in    (cell_timer_in[pin]),
                .pin_in      (port_b_in[pin]),
                .pin_out     (port_b_out[pin]),
                .pin_oe_n    (port_b_oe_n[pin])
            );
        end
    endgenerate

    // high port b pins have their own selector elsewhere; gpio here
    assign b_pattern_lock[15:8] = 8'h00;

    // registered drive for port a and the high port b pins
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            port_a_out        <= 16'h0000;
            port_a_oe_n       <= 16'hffff;
            port_b_out[15:8]  <= 8'h00;
            port_b_oe_n[15:8] <= 8'hff;
        end
        else
        begin
            port_a_out        <= port_a_data;
            port_a_oe_n       <= ~port_a_dir;
            port_b_out[15:8]  <= port_b_data[15:8];
            port_b_oe_n[15:8] <= ~port_b_dir[15:8];
        end
    end

endmodule
`default_nettype wire

// >>> tb/port_pin_function_select_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module port_pin_function_select_monitor
    import pin_select_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // apb
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    input  wire logic [31:0] prdata,
    // port b and peripherals
    input  wire logic [15:0] port_b_in,
    input  wire logic [15:0] port_b_out,
    input  wire logic [15:0] port_b_oe_n,
    input  wire logic        timer_ext_clock_d,
    input  wire logic        timer_ext_clock_c,
    input  wire logic [5:0]  timer_capcomp_in,
    input  wire logic [7:0]  pattern_out,
    // strobes
    input  wire logic        chip_select_1,
    input  wire logic        chip_select_3,
    input  wire logic        upper_column_strobe,
    input  wire logic        lower_column_strobe,
    input  wire logic        strobe_pin_upper,
    input  wire logic        strobe_pin_lower
);
    logic [15:0] low_sel;
    logic [3:0]  strb_sel;
    wire  logic        wr_go = psel && penable && pwrite;
    wire  logic        rd_go = psel && penable && !pwrite;
    wire  logic [15:0] next_low = {pstrb[1] ? pwdata[15:8] : low_sel[15:8],
                                   pstrb[0] ? pwdata[7:0] : low_sel[7:0]};

    // shadow of the selectors, lands on the same edge as the design's write
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            low_sel  <= RESET_PORT_B_LOW_SEL;
            strb_sel <= RESET_STROBE_SEL[15:12];
        end
        else
        begin
            if (wr_go && paddr == ADDR_PORT_B_LOW_SEL)
                low_sel <= next_low;
            if (wr_go && paddr == ADDR_STROBE_SEL && pstrb[1])
                strb_sel <= pwdata[15:12];
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence pattern_held;
        low_sel[1:0] == 2'b11 [*2];
    endsequence
    sequence low_read;
        rd_go && paddr == ADDR_PORT_B_LOW_SEL;
    endsequence

    clock_d_route_a: assert property (
        timer_ext_clock_d == (low_sel[15:14] == 2'b01 ? port_b_in[7] : 1'b0))
        else $error("clock d routing wrong");
    clock_c_route_a: assert property (
        timer_ext_clock_c == (low_sel[13:12] == 2'b01 ? port_b_in[6] : 1'b0))
        else $error("clock c routing wrong");
    capture_route_a: assert property (
        low_sel[11:10] == 2'b10 |-> timer_capcomp_in[5] == port_b_in[5])
        else $error("capture input pin 5 wrong");
    reserved_safe_a: assert property (
        low_sel[9:8] == 2'b01 |-> timer_capcomp_in[4] == 1'b0)
        else $error("reserved mode reached timer");
    pattern_drive_a: assert property (
        pattern_held |-> port_b_out[0] == $past(pattern_out[0]) && !port_b_oe_n[0])
        else $error("pattern output not driven");
    upper_strobe_a: assert property (
        strobe_pin_upper == (strb_sel[3:2] == 2'b10 ? upper_column_strobe : chip_select_1))
        else $error("upper strobe pin wrong");
    lower_strobe_a: assert property (
        strobe_pin_lower == (strb_sel[1:0] == 2'b10 ? lower_column_strobe : chip_select_3))
        else $error("lower strobe pin wrong");
    strobe_ones_a: assert property (
        rd_go && paddr == ADDR_STROBE_SEL |-> prdata == {16'h0000, strb_sel, 12'hfff})
        else $error("strobe selector read wrong");
    low_readback_a: assert property (
        low_read |-> prdata == {16'h0000, low_sel})
        else $error("low selector read wrong");
endmodule

bind port_pin_function_select port_pin_function_select_monitor mon (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .port_b_in(port_b_in), .port_b_out(port_b_out), .port_b_oe_n(port_b_oe_n),
    .timer_ext_clock_d(timer_ext_clock_d), .timer_ext_clock_c(timer_ext_clock_c),
    .timer_capcomp_in(timer_capcomp_in), .pattern_out(pattern_out),
    .chip_select_1(chip_select_1), .chip_select_3(chip_select_3),
    .upper_column_strobe(upper_column_strobe), .lower_column_strobe(lower_column_strobe),
    .strobe_pin_upper(strobe_pin_upper), .strobe_pin_lower(strobe_pin_lower));

`default_nettype wire

// >>> tb/port_pin_function_select_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module port_pin_function_select_tb_top
    import pin_select_pkg::*;
;
    logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, rd_err;
    logic        analog_sampling, tco_b4, tco_a4, clk_d, clk_c;
    logic        cs1, cs3, ucs, lcs, pin_up, pin_lo;
    logic [7:0]  paddr, port_c_in, pattern_out, pattern_enable;
    logic [3:0]  pstrb;
    logic [5:0]  cc_out, cc_drive, cc_in;
    logic [15:0] port_a_in, port_a_out, port_a_oe_n, port_b_in, port_b_out, port_b_oe_n;
    logic [31:0] pwdata, prdata, rd_data;
    int          error_cnt = 0;
    int          checks_done = 0;

    port_pin_function_select dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .port_a_in(port_a_in), .port_a_out(port_a_out),
        .port_a_oe_n(port_a_oe_n), .port_b_in(port_b_in), .port_b_out(port_b_out),
        .port_b_oe_n(port_b_oe_n), .port_c_in(port_c_in), .analog_sampling(analog_sampling),
        .timer_compare_out_b4(tco_b4), .timer_compare_out_a4(tco_a4),
        .timer_ext_clock_d(clk_d), .timer_ext_clock_c(clk_c), .timer_capcomp_out(cc_out),
        .timer_capcomp_drive(cc_drive), .timer_capcomp_in(cc_in),
        .pattern_out(pattern_out), .pattern_enable(pattern_enable),
        .chip_select_1(cs1), .chip_select_3(cs3), .upper_column_strobe(ucs),
        .lower_column_strobe(lcs), .strobe_pin_upper(pin_up), .strobe_pin_lower(pin_lo));

    // 20 MHz system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one apb transfer; an idle edge after it keeps back-to-back calls race free
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        // wait for the slave however long it takes; only the watchdog ends a hang
        do
        begin
            @(posedge clk_sys);
        end
        while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic reset_and_check();
        reset_n <= 1'b0;
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        chk(port_b_oe_n, 16'hffff);
        apb(1'b0, ADDR_PORT_B_LOW_SEL, 32'h0);
        chk(rd_data, 32'h0000_0000);
        apb(1'b0, ADDR_STROBE_SEL, 32'h0);
        chk(rd_data, 32'h0000_5fff);
    endtask

    task automatic report_and_stop();
        $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // watchdog, far beyond the roughly one hundred cycles the tests need
    initial
    begin
        #1000000;
        error_cnt++;
        report_and_stop();
    end

    initial
    begin
        {psel, penable, pwrite, analog_sampling, reset_n} = 5'b00001;
        {paddr, pwdata, pstrb} = '0;
        {tco_b4, tco_a4, cs1, cs3, ucs, lcs} = 6'b101001;
        {cc_out, cc_drive, port_c_in} = {6'h2d, 6'h3f, 8'h3c};
        {pattern_out, pattern_enable} = {8'h96, 8'hff};
        {port_a_in, port_b_in} = {16'h1234, 16'h5a9b};
        reset_and_check();
        pstrb <= 4'hf;
        // every mode code on all eight low pins at once
        for (int i = 0; i < 4; i++)
        begin
            logic [1:0] c;
            c = i[1:0];
            apb(1'b1, ADDR_PORT_B_LOW_SEL, {16'h0, {8{c}}});
            apb(1'b0, ADDR_PORT_B_LOW_SEL, 32'h0);
            chk(rd_data, {16'h0, {8{c}}});
            #1;
            chk(clk_d, c == 2'b01 ? port_b_in[7] : 1'b0);
            chk(clk_c, c == 2'b01 ? port_b_in[6] : 1'b0);
            chk(cc_in, c == 2'b10 ? port_b_in[5:0] : 6'h00);
            chk(port_b_out[7:0], c == 2'b11 ? pattern_out
                : (c == 2'b10 ? {tco_b4, tco_a4, cc_out} : 8'h00));
            chk(port_b_oe_n[7:0], c[1] ? 8'h00 : 8'hff);
        end
        // both strobe fields through every code, reserved ones included
        for (int u = 0; u < 4; u++)
        begin
            logic [3:0] f;
            f = {u[1:0], 2'(3 - u)};
            apb(1'b1, ADDR_STROBE_SEL, {16'h0, f, 12'hfff});
            apb(1'b0, ADDR_STROBE_SEL, 32'h0);
            chk(rd_data, {16'h0, f, 12'hfff});
            chk(pin_up, f[3:2] == 2'b10 ? ucs : cs1);
            chk(pin_lo, f[1:0] == 2'b10 ? lcs : cs3);
        end
        apb(1'b1, ADDR_STROBE_SEL, 32'h0000_6fff);
        apb(1'b0, ADDR_STROBE_SEL, 32'h0);
        chk(rd_data, 32'h0000_6fff);
        // unmapped address is refused
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, rd_err}, 32'h0000_0001);
        chk(rd_data, 32'h0000_0000);
        // input-only port follows its pins, all ones while sampling
        apb(1'b0, ADDR_PORT_C_DATA, 32'h0);
        chk(rd_data[7:0], 8'h3c);
        analog_sampling <= 1'b1;
        apb(1'b0, ADDR_PORT_C_DATA, 32'h0);
        chk(rd_data[7:0], 8'hff);
        // power-on reset in mid-run clears what was written
        apb(1'b1, ADDR_PORT_B_LOW_SEL, 32'h0000_ffff);
        reset_and_check();
        report_and_stop();
    end
endmodule

`default_nettype wire
